// [src/ser_exception_responder.sv]
`timescale 1ns/1ps
// Operation
// - Corrupted message: discard, never reply
// - Unserviceable clean message gets exception response
// - Show exception code on display, decimal
// - Echo function code with MSB set
// - RTU: address, function, code, CRC low-first
// - ASCII: start, hex pairs, LRC, CR LF
// - Unsupported function gives code 01
// - Missing data address gives code 02
// - Unacceptable data value gives code 03
// - Action failure gives code 04
// - Bus silence beyond period raises error 10, only with fault treatment setting 0 or 1
// - Reply waits configurable delay, default 2.0ms
module ser_exception_responder #(
	parameter int unsigned DELAY_UNIT_CYC   = ser_pkg::DELAY_UNIT_CYC,
	parameter int unsigned SILENCE_UNIT_CYC = ser_pkg::SILENCE_UNIT_CYC
) (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              rxDone,
	input  wire logic              rxErr,
	input  wire ser_pkg::ser_req_t req,
	input  wire logic              asciiMode,
	input  wire logic [10:0]       responseDelaySetting,
	input  wire logic [7:0]        timeoutPeriodSetting,
	input  wire logic [1:0]        commFaultTreatmentSetting,
	input  wire logic              txReady,
	output logic [7:0]             txByte,
	output logic                   txValid,
	output ser_pkg::ser_disp_t     disp,
	output logic                   timeoutErr
);

	ser_pkg::ser_state_t state;
	logic [7:0]          excAddr;
	logic [7:0]          excFunc;
	logic [7:0]          excCode;
	logic [7:0]          lrc;
	logic                excAscii;
	logic [3:0]          stepIdx;
	logic [10:0]         delayCnt;
	logic [7:0]          silenceCnt;
	logic                delayTick;
	logic                silenceTick;
	logic [15:0]         crc;
	logic                anyExc;
	logic                accept;
	logic                traffic;
	logic                timeoutEn;
	logic                txDone;
	logic [3:0]          lastStep;
	logic [7:0]          next_code;
	logic [7:0]          next_func;
	logic [7:0]          next_byte;

	function automatic logic [7:0] hexChar(input logic [3:0] n);
		return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction : hexChar

	assign anyExc    = req.badFunc | req.badAddr | req.badValue | req.devFail;
	assign accept    = (state == ser_pkg::ST_IDLE) && rxDone && !rxErr && anyExc;
	assign traffic   = rxDone;
	assign timeoutEn = (timeoutPeriodSetting != 8'h00) && (commFaultTreatmentSetting <= 2'h1);
	assign txDone    = txValid && txReady;
	assign lastStep  = excAscii ? ser_pkg::ASCII_LAST_STEP : ser_pkg::RTU_LAST_STEP;
	assign next_func = req.func | 8'h80;

	// Cause to code, first failing check wins
	always_comb
	begin
		if (req.badFunc)
			next_code = ser_pkg::EXC_BAD_FUNC;
		else if (req.badAddr)
			next_code = ser_pkg::EXC_BAD_ADDR;
		else if (req.badValue)
			next_code = ser_pkg::EXC_BAD_VALUE;
		else
			next_code = ser_pkg::EXC_DEV_FAIL;
	end

	// Byte for the current frame step
	always_comb
	begin
		logic [3:0] fieldIdx;
		logic [7:0] field;
		fieldIdx = (stepIdx - 4'h1) >> 1;
		field    = ser_pkg::BYTE_RESET;
		unique case (fieldIdx)
			4'h0: field = excAddr;
			4'h1: field = excFunc;
			4'h2: field = excCode;
			default: field = lrc;
		endcase
		if (excAscii)
		begin
			if (stepIdx == ser_pkg::STEP_RESET)
				next_byte = ser_pkg::ASCII_START;
			else if (stepIdx == ser_pkg::ASCII_CR_STEP)
				next_byte = ser_pkg::ASCII_CR;
			else if (stepIdx == ser_pkg::ASCII_LAST_STEP)
				next_byte = ser_pkg::ASCII_LF;
			else
				next_byte = hexChar(stepIdx[0] ? field[7:4] : field[3:0]);
		end
		else
		begin
			unique case (stepIdx)
				4'h0: next_byte = excAddr;
				4'h1: next_byte = excFunc;
				4'h2: next_byte = excCode;
				4'h3: next_byte = crc[7:0];
				default: next_byte = crc[15:8];
			endcase
		end
	end

	ser_tick #(.PERIOD(DELAY_UNIT_CYC)) delayTimer (
		.core_clk (core_clk),
		.rst      (rst),
		.restart  (accept),
		.tick     (delayTick)
	);

	ser_tick #(.PERIOD(SILENCE_UNIT_CYC)) silenceTimer (
		.core_clk (core_clk),
		.rst      (rst),
		.restart  (traffic || !timeoutEn),
		.tick     (silenceTick)
	);

	ser_crc16 crcGen (
		.core_clk (core_clk),
		.rst      (rst),
		.init     (accept),
		.en       (txDone && !excAscii && (stepIdx < 4'h3)),
		.data     (txByte),
		.crc      (crc)
	);

	// Sequencer
	always_ff @(posedge core_clk)
	begin
		if (rst)
			state <= ser_pkg::ST_IDLE;
		else
		begin
			unique case (state)
				ser_pkg::ST_IDLE:
					if (accept)
						state <= (responseDelaySetting == 11'h000) ? ser_pkg::ST_SEND : ser_pkg::ST_DELAY;
				ser_pkg::ST_DELAY:
					if (delayTick && (delayCnt == 11'h001))
						state <= ser_pkg::ST_SEND;
				ser_pkg::ST_SEND:
					if (txDone && (stepIdx == lastStep))
						state <= ser_pkg::ST_IDLE;
				default:
					state <= ser_pkg::ST_IDLE;
			endcase
		end
	end

	// Captured reply fields
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			excAddr  <= ser_pkg::BYTE_RESET;
			excFunc  <= ser_pkg::BYTE_RESET;
			excCode  <= ser_pkg::BYTE_RESET;
			lrc      <= ser_pkg::BYTE_RESET;
			excAscii <= 1'b0;
		end
		else if (accept)
		begin
			excAddr  <= req.addr;
			excFunc  <= next_func;
			excCode  <= next_code;
			lrc      <= 8'(8'h00 - (req.addr + next_func + next_code));
			excAscii <= asciiMode;
		end
	end

	// Reply delay counter
	always_ff @(posedge core_clk)
	begin
		if (rst)
			delayCnt <= ser_pkg::DCNT_RESET;
		else if (accept)
			delayCnt <= responseDelaySetting;
		else if ((state == ser_pkg::ST_DELAY) && delayTick)
			delayCnt <= delayCnt - 11'h001;
	end

	// Transmit handshake
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			txValid <= 1'b0;
			txByte  <= ser_pkg::BYTE_RESET;
			stepIdx <= ser_pkg::STEP_RESET;
		end
		else if (state != ser_pkg::ST_SEND)
		begin
			txValid <= 1'b0;
			stepIdx <= ser_pkg::STEP_RESET;
		end
		else if (txDone)
		begin
			txValid <= 1'b0;
			stepIdx <= stepIdx + 4'h1;
		end
		else if (!txValid)
		begin
			txValid <= 1'b1;
			txByte  <= next_byte;
		end
	end

	// Display indication
	always_ff @(posedge core_clk)
	begin
		if (rst)
			disp <= '0;
		else if (accept)
			disp <= '{show: 1'b1, code: next_code};
		else if (timeoutEn && !timeoutErr && (silenceCnt == timeoutPeriodSetting))
			disp <= '{show: 1'b1, code: ser_pkg::EXC_TIMEOUT};
	end

	// Bus silence watch
	always_ff @(posedge core_clk)
	begin
		if (rst || traffic || !timeoutEn)
			silenceCnt <= ser_pkg::SCNT_RESET;
		else if (silenceTick && (silenceCnt != ser_pkg::SCNT_MAX))
			silenceCnt <= silenceCnt + 8'h01;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst || traffic || !timeoutEn)
			timeoutErr <= 1'b0;
		else if (silenceCnt == timeoutPeriodSetting)
			timeoutErr <= 1'b1;
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	sequence sAccept;
		accept;
	endsequence

	sequence sBadRx;
		(state == ser_pkg::ST_IDLE) && rxDone && rxErr;
	endsequence

	sequence sSilenceHit;
		timeoutEn && !timeoutErr && !traffic && (silenceCnt == timeoutPeriodSetting);
	endsequence

	errSilent_a: assert property (sBadRx |=> (state == ser_pkg::ST_IDLE) && !txValid)
		else $error("reply started for a corrupted message");
	excStart_a: assert property (sAccept |=> (state != ser_pkg::ST_IDLE))
		else $error("exception not started");
	dispCode_a: assert property (sAccept |=> disp.show && (disp.code == $past(next_code)))
		else $error("display code mismatch");
	funcMsb_a: assert property (sAccept |=> excFunc[7] && (excFunc[6:0] == $past(req.func[6:0])))
		else $error("function byte not flagged");
	crcLow_a: assert property (txValid && !excAscii && (stepIdx == 4'h3) |-> txByte == crc[7:0])
		else $error("crc low byte wrong");
	crcHigh_a: assert property (txValid && !excAscii && (stepIdx == 4'h4) |-> txByte == crc[15:8])
		else $error("crc high byte wrong");
	asciiEnd_a: assert property (txValid && excAscii && (stepIdx == 4'hA) |-> txByte == 8'h0A)
		else $error("ascii frame not ended by line feed");
	asciiStart_a: assert property (txValid && excAscii && (stepIdx == 4'h0) |-> txByte == 8'h3A)
		else $error("ascii frame start missing");
	codeFunc_a: assert property (sAccept ##0 req.badFunc |=> excCode == 8'h01)
		else $error("code 01 expected");
	codeAddr_a: assert property (sAccept ##0 (!req.badFunc && req.badAddr) |=> excCode == 8'h02)
		else $error("code 02 expected");
	codeValue_a: assert property (sAccept ##0 (req.badValue && !req.badFunc && !req.badAddr) |=> excCode == 8'h03)
		else $error("code 03 expected");
	codeFail_a: assert property (sAccept ##0 (req.devFail && !req.badFunc && !req.badAddr && !req.badValue)
		|=> excCode == 8'h04)
		else $error("code 04 expected");
	silenceErr_a: assert property (timeoutEn && !traffic && (silenceCnt == timeoutPeriodSetting)
		##1 timeoutEn && !traffic |-> timeoutErr)
		else $error("silence timeout not raised");
	delayHold_a: assert property ((state == ser_pkg::ST_DELAY) && (delayCnt > 11'h001) |=> state != ser_pkg::ST_SEND)
		else $error("reply sent before delay elapsed");
	silenceIdle_a: assert property ((traffic || !timeoutEn) |=> (silenceCnt == 8'h00) && !timeoutErr)
		else $error("silence timer not restarted");
	txHold_a: assert property (txValid && !txReady |=> txValid && $stable(txByte))
		else $error("byte changed before it was taken");
	timeoutDisp_a: assert property (sSilenceHit |=> disp.show && (disp.code == ser_pkg::EXC_TIMEOUT))
		else $error("timeout code not shown");
	directSend_a: assert property (sAccept ##0 (responseDelaySetting == 11'h000) |=> state == ser_pkg::ST_SEND)
		else $error("reply without delay not started");
	delayEnd_a: assert property ((state == ser_pkg::ST_DELAY) && delayTick && (delayCnt == 11'h001)
		|=> state == ser_pkg::ST_SEND)
		else $error("reply not started after delay");

endmodule : ser_exception_responder

// [src/ser_pkg.sv]
package ser_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS    = 8;
	localparam int DELAY_UNIT_NS    = 100000;
	localparam int DELAY_UNIT_CYC   = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SILENCE_UNIT_MS  = 100;
	localparam int SILENCE_UNIT_CYC = (SILENCE_UNIT_MS * 1000000) / CLK_PERIOD_NS;

	// Exception codes, decimal digits packed as two BCD nibbles
	localparam logic [7:0] EXC_BAD_FUNC  = 8'h01;
	localparam logic [7:0] EXC_BAD_ADDR  = 8'h02;
	localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
	localparam logic [7:0] EXC_DEV_FAIL  = 8'h04;
	localparam logic [7:0] EXC_TIMEOUT   = 8'h10;

	// Framing
	localparam int         FUNC_EXC_BIT    = 7;
	localparam logic [7:0] ASCII_START     = 8'h3A;
	localparam logic [7:0] ASCII_CR        = 8'h0D;
	localparam logic [7:0] ASCII_LF        = 8'h0A;
	localparam logic [3:0] RTU_LAST_STEP   = 4'h4;
	localparam logic [3:0] ASCII_LAST_STEP = 4'hA;
	localparam logic [3:0] ASCII_CR_STEP   = 4'h9;
	localparam logic [15:0] CRC_INIT       = 16'hFFFF;
	localparam logic [15:0] CRC_POLY       = 16'hA001;

	// Reset values and silence count limit
	localparam logic [7:0]  BYTE_RESET  = 8'h00;
	localparam logic [10:0] DCNT_RESET  = 11'h000;
	localparam logic [7:0]  SCNT_RESET  = 8'h00;
	localparam logic [7:0]  SCNT_MAX    = 8'hFF;
	localparam logic [3:0]  STEP_RESET  = 4'h0;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] func;
		logic       badFunc;
		logic       badAddr;
		logic       badValue;
		logic       devFail;
	} ser_req_t;

	typedef struct packed {
		logic       show;
		logic [7:0] code;
	} ser_disp_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_DELAY = 3'b010,
		ST_SEND  = 3'b100
	} ser_state_t;

endpackage : ser_pkg

// [src/ser_tick.sv]
`timescale 1ns/1ps
module ser_tick #(
	parameter int unsigned PERIOD = 16
) (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic restart,
	output logic      tick
);

	logic [31:0] cnt;

	// Counts PERIOD cycles from the last restart, then pulses
	always_ff @(posedge core_clk)
	begin
		if (rst || restart)
		begin
			cnt  <= 32'h0;
			tick <= 1'b0;
		end
		else if (cnt == 32'(PERIOD - 1))
		begin
			cnt  <= 32'h0;
			tick <= 1'b1;
		end
		else
		begin
			cnt  <= cnt + 32'h1;
			tick <= 1'b0;
		end
	end

endmodule : ser_tick

// [src/ser_crc16.sv]
`timescale 1ns/1ps
module ser_crc16 (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        init,
	input  wire logic        en,
	input  wire logic [7:0]  data,
	output logic      [15:0] crc
);

	function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
		begin
			r = r[0] ? ((r >> 1) ^ ser_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crcStep

	always_ff @(posedge core_clk)
	begin
		if (rst || init)
			crc <= ser_pkg::CRC_INIT;
		else if (en)
			crc <= crcStep(crc, data);
	end

endmodule : ser_crc16

// [dv/ser_master_model.sv]
`timescale 1ns/1ps
module ser_master_model (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       slow,
	input  wire logic       txValid,
	input  wire logic [7:0] txByte,
	output logic            txReady
);
	logic [1:0] cnt   = 2'h0;
	logic [7:0] got[$];
	int         quiet = 0;

	// Slow mode takes one byte in four cycles
	assign txReady = !rst && (!slow || cnt == 2'h3);

	// Byte capture and own reply timer
	always @(posedge core_clk)
	begin
		cnt <= cnt + 2'h1;
		if (txValid && txReady)
		begin
			got.push_back(txByte);
			quiet <= 0;
		end
		else
			quiet <= quiet + 1;
	end
endmodule : ser_master_model

// [dv/tb_ser_exception_responder.sv]
`timescale 1ns/1ps
module tb_ser_exception_responder;
	logic               core_clk                  = 1'b0;
	logic               rst                       = 1'b1;
	logic               rxDone                    = 1'b0;
	logic               rxErr                     = 1'b0;
	ser_pkg::ser_req_t  req                       = '0;
	logic               asciiMode                 = 1'b0;
	logic [10:0]        responseDelaySetting      = 11'h000;
	logic [7:0]         timeoutPeriodSetting      = 8'h00;
	logic [1:0]         commFaultTreatmentSetting = 2'h0;
	logic               slow                      = 1'b0;
	logic               txReady;
	logic               txValid;
	logic               timeoutErr;
	logic [7:0]         txByte;
	ser_pkg::ser_disp_t disp;
	int                 fail_count                = 0;
	int                 compares                  = 0;

	always #4 core_clk = ~core_clk;

	ser_exception_responder #(.DELAY_UNIT_CYC(4), .SILENCE_UNIT_CYC(8)) uut (
		.core_clk(core_clk), .rst(rst), .rxDone(rxDone), .rxErr(rxErr), .req(req),
		.asciiMode(asciiMode), .responseDelaySetting(responseDelaySetting),
		.timeoutPeriodSetting(timeoutPeriodSetting), .commFaultTreatmentSetting(commFaultTreatmentSetting),
		.txReady(txReady), .txByte(txByte), .txValid(txValid), .disp(disp), .timeoutErr(timeoutErr)
	);

	ser_master_model mdl (
		.core_clk(core_clk), .rst(rst), .slow(slow), .txValid(txValid), .txByte(txByte), .txReady(txReady)
	);

	task automatic test_done;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[k])
		begin
			c = c ^ {8'h00, b[k]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction : crc16

	// Flags in order badFunc, badAddr, badValue, devFail
	task automatic message(input logic [7:0] a, input logic [7:0] f, input logic [3:0] fl, input logic e);
		@(posedge core_clk);
		req    <= '{addr: a, func: f, badFunc: fl[3], badAddr: fl[2], badValue: fl[1], devFail: fl[0]};
		rxErr  <= e;
		rxDone <= 1'b1;
		@(posedge core_clk);
		rxDone <= 1'b0;
	endtask : message

	task automatic frame(input logic [7:0] exp[$]);
		int i;
		for (i = 0; i < 600 && mdl.got.size() < exp.size(); i++)
			cyc(1);
		cyc(4);
		check("frame length", 16'(mdl.got.size()), 16'(exp.size()));
		if (i == 600)
			test_done();
		foreach (exp[k])
			check("frame byte", mdl.got[k], exp[k]);
		mdl.got.delete();
	endtask : frame

	task automatic rtu_codes;
		logic [7:0]  b[$];
		logic [15:0] c;
		for (int k = 0; k < 4; k++)
		begin
			message(8'h11, 8'h03 + 8'(k), (4'h8 >> k) | 4'h1, 1'b0);
			cyc(1);
			#1;
			check("display code", disp, {1'b1, 8'(k + 1)});
			b = '{8'h11, 8'h83 + 8'(k), 8'(k + 1)};
			c = crc16(b);
			b.push_back(c[7:0]);
			b.push_back(c[15:8]);
			frame(b);
		end
	endtask : rtu_codes

	task automatic delayed_example;
		int n;
		@(posedge core_clk);
		responseDelaySetting <= 11'h003;
		message(8'h01, 8'h06, 4'h4, 1'b0);
		n = 0;
		do
		begin
			cyc(1);
			#1;
			n++;
		end while (n < 100 && txValid !== 1'b1);
		check("reply delay", n >= 12 && n <= 16, 16'h1);
		if (n == 100)
			test_done();
		frame('{8'h01, 8'h86, 8'h02, 8'hC3, 8'hA1});
		responseDelaySetting <= 11'h000;
	endtask : delayed_example

	task automatic ascii_slow;
		@(posedge core_clk);
		asciiMode <= 1'b1;
		slow      <= 1'b1;
		message(8'h01, 8'h06, 4'h6, 1'b0);
		frame('{8'h3A, 8'h30, 8'h31, 8'h38, 8'h36, 8'h30, 8'h32, 8'h37, 8'h37, 8'h0D, 8'h0A});
		asciiMode <= 1'b0;
		slow      <= 1'b0;
	endtask : ascii_slow

	task automatic corrupt;
		message(8'h01, 8'h06, 4'h8, 1'b1);
		cyc(200);
		check("bytes after corrupt", 16'(mdl.got.size()), 16'h0);
		check("display after corrupt", disp, 16'h102);
		check("master reply timer", 16'(mdl.quiet >= 150), 16'h1);
	endtask : corrupt

	task automatic silence;
		for (int t = 0; t < 5; t++)
		begin
			@(posedge core_clk);
			timeoutPeriodSetting      <= (t == 4) ? 8'h00 : 8'h02;
			commFaultTreatmentSetting <= 2'(t);
			message(8'h01, 8'h06, 4'h0, 1'b0);
			cyc(10);
			#1;
			check("early timeout", timeoutErr, 16'h0);
			cyc(20);
			#1;
			check("timeout flag", timeoutErr, 16'(t < 2));
			if (t < 2)
				check("timeout display", disp, 16'h110);
			message(8'h01, 8'h06, 4'h0, 1'b0);
			cyc(2);
			#1;
			check("timeout cleared", timeoutErr, 16'h0);
		end
		check("silent replies", 16'(mdl.got.size()), 16'h0);
	endtask : silence

	initial
	begin
		cyc(8);
		rst <= 1'b0;
		rtu_codes();
		delayed_example();
		ascii_slow();
		corrupt();
		silence();
		test_done();
	end
endmodule : tb_ser_exception_responder
